/* hdl/eeac_pkg.sv */
// constants, register map and types for the nonvolatile byte access controller
// assumes the cpu core presents one io access per cycle on ref_clk
package eeac_pkg;
    // address space layout
    localparam logic [7:0] IO_LAST = 8'h3F;
    localparam logic [7:0] BIT_LAST = 8'h1F;
    localparam logic [7:0] IO_DS_OFFSET = 8'h20;
    localparam logic [7:0] IO_DS_LAST = IO_LAST + IO_DS_OFFSET;

    // register offsets in io space
    localparam logic [7:0] OFF_CONTROL = 8'h1C;
    localparam logic [7:0] OFF_DATA = 8'h1D;
    localparam logic [7:0] OFF_ADDR_LOW = 8'h1E;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h1F;

    // control register field positions
    localparam int CTL_READ_STROBE = 0;
    localparam int CTL_PROG_ENABLE = 1;
    localparam int CTL_MASTER_ENABLE = 2;
    localparam int CTL_READY_IRQ_EN = 3;
    localparam int CTL_MODE_LO = 4;
    localparam int CTL_MODE_HI = 5;
    localparam int ADDR_HIGH_BIT = 0;

    // array geometry
    localparam int ADDR_W = 9;
    localparam int ARRAY_BYTES = 512;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [7:0] BIT_ONE = 8'h01;

    // programming modes
    localparam logic [1:0] MODE_ATOMIC = 2'h0;
    localparam logic [1:0] MODE_ERASE = 2'h1;
    localparam logic [1:0] MODE_WRITE = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;

    // cpu-cycle windows
    localparam logic [2:0] MASTER_WINDOW = 3'h4;
    localparam logic [2:0] STALL_PROG = 3'h2;
    localparam logic [2:0] STALL_READ = 3'h4;

    // programming times
    localparam int CLK_PERIOD_NS = 8;
    localparam int ATOMIC_TIME_NS = 3400000;
    localparam int SPLIT_TIME_NS = 1800000;
    localparam int CNT_W = 20;
    localparam int OSC_W = 8;

    typedef enum logic {
        EEAC_IDLE,
        EEAC_PROG
    } eeac_state_t;
endpackage

/* hdl/eeac_top.sv */
// nonvolatile byte access controller: io registers, read path, timed programming
// assumes the cpu honours cpu_stall and drives one access per cycle;
// por_rst is power-on only, so a running programming cycle outlives sys_rst
`timescale 1ns/10ps

// Summary of operation
// - reset lets a running program cycle finish
// - registers at io address, data space plus 0x20
// - low io registers take single-bit set/clear/test
// - address high bits 7:1 read zero
// - nine-bit linear byte address over two registers
// - data register: write source, read result
// - mode 00 atomic, 01 erase, 10 write
// - mode bits frozen while programming
// - reset clears mode unless programming
// - ready irq level when enabled and idle
// - master enable self-clears after four cycles
// - program start needs master enable window
// - program enable stays set until done
// - program start stalls cpu two cycles
// - read strobe loads data register at once
// - read strobe stalls cpu four cycles
// - programming refuses reads and address changes
// - reset clears irq, master, strobe; top zero
// - no other array operation while busy
// - durations timed by ref_clk divided by OSC_DIV
module eeac_top
    import eeac_pkg::*;
#(
    parameter int OSC_DIV = 16,
    parameter int ATOMIC_TICKS =
        (ATOMIC_TIME_NS + CLK_PERIOD_NS * OSC_DIV - 1) / (CLK_PERIOD_NS * OSC_DIV),
    parameter int SPLIT_TICKS =
        (SPLIT_TIME_NS + CLK_PERIOD_NS * OSC_DIV - 1) / (CLK_PERIOD_NS * OSC_DIV)
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic [7:0] bus_addr,
    input wire logic bus_io_space,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_bit_set,
    input wire logic bus_bit_clr,
    input wire logic [2:0] bus_bit_idx,
    input wire logic [7:0] bus_wdata,
    input wire logic global_irq_en,
    output logic [7:0] bus_rdata,
    output logic bus_bit_tst,
    output logic cpu_stall,
    output logic ready_irq,
    output logic prog_busy
);
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);
    localparam logic [CNT_W-1:0] ATOMIC_LAST = CNT_W'(ATOMIC_TICKS - 1);
    localparam logic [CNT_W-1:0] SPLIT_LAST = CNT_W'(SPLIT_TICKS - 1);

    // control group, cleared by sys_rst
    logic ready_irq_enable_reg, ready_irq_enable_next;
    logic [2:0] master_cnt_reg, master_cnt_next;
    logic [2:0] stall_cnt_reg, stall_cnt_next;
    logic [7:0] data_reg, data_next;
    logic [ADDR_W-1:0] byte_address_reg, byte_address_next;
    logic [7:0] rdata_reg, rdata_next;
    logic bit_tst_reg, bit_tst_next;

    // engine group, survives sys_rst
    eeac_state_t state_reg, state_next;
    logic [1:0] prog_mode_bits_reg, prog_mode_bits_next;
    logic [OSC_W-1:0] osc_cnt_reg, osc_cnt_next;
    logic [CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic [ADDR_W-1:0] prog_addr_reg, prog_addr_next;
    logic [7:0] prog_data_reg, prog_data_next;
    logic [1:0] rst_sync_reg, rst_sync_next;

    logic [7:0] nv_array [ARRAY_BYTES];

    // decode and strobes shared by both groups
    logic [7:0] eff_addr, wmask, wval, rval;
    logic hit, bitop, wr_any, sel_ctrl, sel_data, sel_lo, sel_hi;
    logic master_prog_enable, idle, start, read_go, mode_wr, osc_tick, commit;
    logic [1:0] mode_eff;
    logic [7:0] commit_val;
    logic [CNT_W-1:0] term;

    assign master_prog_enable = (master_cnt_reg != 3'h0);
    assign idle = (state_reg == EEAC_IDLE);

    // io and data-space decode; bit ops only reach the low io range
    always_comb begin
        eff_addr = bus_io_space ? bus_addr : bus_addr - IO_DS_OFFSET;
        hit = bus_io_space ? (bus_addr <= IO_LAST) :
            (bus_addr >= IO_DS_OFFSET && bus_addr <= IO_DS_LAST);
        bitop = (bus_bit_set || bus_bit_clr) && bus_io_space && (bus_addr <= BIT_LAST);
        wmask = BYTE_ZERO;
        wval = BYTE_ZERO;
        wr_any = 1'b0;
        if (bitop) begin
            // only the addressed bit is touched, so flags beside it are safe
            wmask = BIT_ONE << bus_bit_idx;
            wval = bus_bit_set ? BYTE_ONES : BYTE_ZERO;
            wr_any = 1'b1;
        end else if (bus_wr && hit) begin
            wmask = BYTE_ONES;
            wval = bus_wdata;
            wr_any = 1'b1;
        end
        sel_ctrl = wr_any && (eff_addr == OFF_CONTROL);
        sel_data = wr_any && (eff_addr == OFF_DATA);
        sel_lo = wr_any && (eff_addr == OFF_ADDR_LOW);
        sel_hi = wr_any && (eff_addr == OFF_ADDR_HIGH);
        rval = BYTE_ZERO;
        if (!hit) begin
            rval = BYTE_ZERO;
        end else if (eff_addr == OFF_CONTROL) begin
            // top two bits and the strobe always read zero
            rval[CTL_MODE_HI] = prog_mode_bits_reg[1];
            rval[CTL_MODE_LO] = prog_mode_bits_reg[0];
            rval[CTL_READY_IRQ_EN] = ready_irq_enable_reg;
            rval[CTL_MASTER_ENABLE] = master_prog_enable;
            rval[CTL_PROG_ENABLE] = !idle;
        end else if (eff_addr == OFF_DATA) begin
            rval = data_reg;
        end else if (eff_addr == OFF_ADDR_LOW) begin
            rval = byte_address_reg[7:0];
        end else if (eff_addr == OFF_ADDR_HIGH) begin
            rval[ADDR_HIGH_BIT] = byte_address_reg[ADDR_W-1];
        end
        mode_eff[1] = wmask[CTL_MODE_HI] ? wval[CTL_MODE_HI] : prog_mode_bits_reg[1];
        mode_eff[0] = wmask[CTL_MODE_LO] ? wval[CTL_MODE_LO] : prog_mode_bits_reg[0];
        mode_wr = sel_ctrl && (wmask[CTL_MODE_HI] || wmask[CTL_MODE_LO]) && idle;
        // start only inside the master window, never while busy
        start = sel_ctrl && wmask[CTL_PROG_ENABLE] && wval[CTL_PROG_ENABLE]
            && master_prog_enable && idle && (mode_eff != MODE_RESERVED);
        read_go = sel_ctrl && wmask[CTL_READ_STROBE] && wval[CTL_READ_STROBE]
            && idle && !start;
    end

    // control group next values
    always_comb begin
        ready_irq_enable_next = ready_irq_enable_reg;
        master_cnt_next = master_cnt_reg;
        stall_cnt_next = stall_cnt_reg;
        data_next = data_reg;
        byte_address_next = byte_address_reg;
        rdata_next = rdata_reg;
        bit_tst_next = bit_tst_reg;
        if (sel_ctrl && wmask[CTL_READY_IRQ_EN]) begin
            ready_irq_enable_next = wval[CTL_READY_IRQ_EN];
        end
        // window counter: master enable reads set for exactly four cycles
        if (sel_ctrl && wmask[CTL_MASTER_ENABLE]) begin
            master_cnt_next = wval[CTL_MASTER_ENABLE] ? MASTER_WINDOW : 3'h0;
        end else if (master_prog_enable) begin
            master_cnt_next = master_cnt_reg - 3'h1;
        end
        if (start) begin
            stall_cnt_next = STALL_PROG;
        end else if (read_go) begin
            stall_cnt_next = STALL_READ;
        end else if (stall_cnt_reg != 3'h0) begin
            stall_cnt_next = stall_cnt_reg - 3'h1;
        end
        if (read_go) begin
            data_next = nv_array[byte_address_reg];
        end else if (sel_data) begin
            data_next = (data_reg & ~wmask) | (wval & wmask);
        end
        // address frozen while programming
        if (idle && sel_lo) begin
            byte_address_next[7:0] = (byte_address_reg[7:0] & ~wmask) | (wval & wmask);
        end
        if (idle && sel_hi && wmask[ADDR_HIGH_BIT]) begin
            byte_address_next[ADDR_W-1] = wval[ADDR_HIGH_BIT];
        end
        if (bus_rd || bitop) begin
            rdata_next = rval;
            bit_tst_next = rval[bus_bit_idx];
        end
    end

    // address given a defined value although software must load it first
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ready_irq_enable_reg <= 1'b0;
            master_cnt_reg <= 3'h0;
            stall_cnt_reg <= 3'h0;
            data_reg <= BYTE_ZERO;
            byte_address_reg <= '0;
            rdata_reg <= BYTE_ZERO;
            bit_tst_reg <= 1'b0;
        end else begin
            ready_irq_enable_reg <= ready_irq_enable_next;
            master_cnt_reg <= master_cnt_next;
            stall_cnt_reg <= stall_cnt_next;
            data_reg <= data_next;
            byte_address_reg <= byte_address_next;
            rdata_reg <= rdata_next;
            bit_tst_reg <= bit_tst_next;
        end
    end

    // engine: oscillator divider, mode, programming timer
    always_comb begin
        state_next = state_reg;
        prog_mode_bits_next = prog_mode_bits_reg;
        prog_addr_next = prog_addr_reg;
        prog_data_next = prog_data_reg;
        tick_cnt_next = tick_cnt_reg;
        rst_sync_next = {rst_sync_reg[0], sys_rst};
        osc_tick = (osc_cnt_reg == OSC_LAST);
        osc_cnt_next = osc_tick ? '0 : osc_cnt_reg + 8'h01;
        term = (prog_mode_bits_reg == MODE_ATOMIC) ? ATOMIC_LAST : SPLIT_LAST;
        commit = 1'b0;
        case (prog_mode_bits_reg)
            MODE_ERASE: commit_val = ERASED_BYTE;
            MODE_WRITE: commit_val = nv_array[prog_addr_reg] & prog_data_reg;
            default: commit_val = prog_data_reg;
        endcase
        // a system reset with no cycle running drops the mode to atomic
        if (rst_sync_reg[1] && idle) begin
            prog_mode_bits_next = MODE_ATOMIC;
        end else if (mode_wr) begin
            prog_mode_bits_next = mode_eff;
        end
        case (state_reg)
            EEAC_IDLE: begin
                if (start) begin
                    state_next = EEAC_PROG;
                    prog_addr_next = byte_address_reg;
                    prog_data_next = data_reg;
                    tick_cnt_next = '0;
                end
            end
            EEAC_PROG: begin
                // counted in oscillator ticks of OSC_DIV ref_clk cycles, so the time scales with the cpu clock
                if (osc_tick) begin
                    if (tick_cnt_reg == term) begin
                        commit = 1'b1;
                        state_next = EEAC_IDLE;
                    end else begin
                        tick_cnt_next = tick_cnt_reg + 20'h1;
                    end
                end
            end
            default: state_next = EEAC_IDLE;
        endcase
    end

    // sys_rst is not in this list, so a running cycle completes
    always_ff @(posedge ref_clk or posedge por_rst) begin
        if (por_rst) begin
            state_reg <= EEAC_IDLE;
            prog_mode_bits_reg <= MODE_ATOMIC;
            osc_cnt_reg <= '0;
            tick_cnt_reg <= '0;
            prog_addr_reg <= '0;
            prog_data_reg <= BYTE_ZERO;
            rst_sync_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            prog_mode_bits_reg <= prog_mode_bits_next;
            osc_cnt_reg <= osc_cnt_next;
            tick_cnt_reg <= tick_cnt_next;
            prog_addr_reg <= prog_addr_next;
            prog_data_reg <= prog_data_next;
            rst_sync_reg <= rst_sync_next;
        end
    end

    // array contents are the stored data, never reset
    always_ff @(posedge ref_clk) begin
        if (commit) begin
            nv_array[prog_addr_reg] <= commit_val;
        end
    end

    // outputs
    assign bus_rdata = rdata_reg;
    assign bus_bit_tst = bit_tst_reg;
    assign cpu_stall = (stall_cnt_reg != 3'h0);
    assign ready_irq = ready_irq_enable_reg && global_irq_en && idle;
    assign prog_busy = !idle;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst || por_rst);

    a_master_window: assert property (
        (sel_ctrl && wmask[CTL_MASTER_ENABLE] && wval[CTL_MASTER_ENABLE])
        |=> master_prog_enable [*4])
        else $error("master enable not held four cycles");
    a_master_clears: assert property (
        (master_cnt_reg == 3'h1 && !(sel_ctrl && wmask[CTL_MASTER_ENABLE]))
        |=> !master_prog_enable)
        else $error("master enable did not self clear");
    a_start_needs_master: assert property (
        $rose(prog_busy) |-> $past(master_prog_enable))
        else $error("programming began without master enable");
    a_stall_prog: assert property (
        start |=> cpu_stall [*2] ##1 !cpu_stall)
        else $error("program stall not two cycles");
    a_stall_read: assert property (
        read_go |=> cpu_stall [*4] ##1 !cpu_stall)
        else $error("read stall not four cycles");
    a_read_refused: assert property (
        (prog_busy && !sel_data) |=> $stable(data_reg))
        else $error("data changed by read while busy");
    a_addr_frozen: assert property (
        prog_busy |=> $stable(byte_address_reg))
        else $error("address changed while busy");
    a_mode_frozen: assert property (
        prog_busy |=> $stable(prog_mode_bits_reg))
        else $error("mode changed while busy");
    a_prog_length: assert property (
        $fell(prog_busy) |-> ($past(tick_cnt_reg) == $past(term)) && $past(osc_tick))
        else $error("programming ended early");
    // level request must persist while ready, unless software or a start removes it
    a_irq_ready: assert property (
        (ready_irq && !start && !(sel_ctrl && wmask[CTL_READY_IRQ_EN]))
        |=> (ready_irq || !global_irq_en))
        else $error("ready irq dropped while ready");
    a_high_zero: assert property (
        $past(bus_rd && hit && eff_addr == OFF_ADDR_HIGH) |-> (bus_rdata[7:1] == 7'h00))
        else $error("address high upper bits not zero");
    a_reset_no_abort: assert property (@(posedge ref_clk) disable iff (por_rst)
        (prog_busy && sys_rst && !commit) |=> prog_busy)
        else $error("reset aborted programming");
endmodule

/* tb/eeac_cpu_model.sv */
// cpu core model: issues io and data-space register accesses one at a time
// assumes the controller samples on posedge ref_clk and raises cpu_stall
`timescale 1ns/10ps
module eeac_cpu_model
    import eeac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic cpu_stall,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_bit_tst,
    output logic [7:0] bus_addr,
    output logic bus_io_space,
    output logic bus_wr,
    output logic bus_rd,
    output logic bus_bit_set,
    output logic bus_bit_clr,
    output logic [2:0] bus_bit_idx,
    output logic [7:0] bus_wdata
);
    // idle bus: strobes low, address and data inverted so stale values never look valid
    task automatic release_bus();
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_bit_set = 1'b0;
        bus_bit_clr = 1'b0;
        bus_addr = ~bus_addr;
        bus_wdata = ~bus_wdata;
    endtask

    // time-zero values of every bus line
    initial begin
        bus_addr = 8'h00;
        bus_io_space = 1'b1;
        bus_wdata = 8'h00;
        bus_bit_idx = 3'h0;
        release_bus();
    end

    // next free cycle; the core stands still while stalled
    task automatic slot();
        @(posedge ref_clk);
        #1;
        while (cpu_stall === 1'b1) begin
            @(posedge ref_clk);
            #1;
        end
    endtask

    // op 0 write, 1 read, 2 bit set, 3 bit clear; d[2:0] is the bit index
    task automatic acc(input logic [1:0] op, input logic [7:0] a, input logic io,
                       input logic [7:0] d, output logic [7:0] q, output logic t);
        slot();
        bus_addr = io ? a : a + IO_DS_OFFSET;
        bus_io_space = io;
        bus_wdata = d;
        bus_bit_idx = d[2:0];
        bus_wr = (op == 2'h0);
        bus_rd = (op == 2'h1);
        bus_bit_set = (op == 2'h2);
        bus_bit_clr = (op == 2'h3);
        @(posedge ref_clk);
        #1;
        release_bus();
        q = 8'h00;
        t = 1'b0;
        // read answer is registered at the take edge and sampled one cycle later
        if (op == 2'h1) begin
            @(posedge ref_clk);
            #1;
            q = bus_rdata;
            t = bus_bit_tst;
        end
    endtask

    // polls program enable low before any array read; bounded
    task automatic wait_ready();
        logic [7:0] v;
        logic b;
        int n;
        n = 0;
        v = 8'hFF;
        while (v[1] !== 1'b0 && n < 200) begin
            acc(2'h1, OFF_CONTROL, 1'b1, 8'h00, v, b);
            n++;
        end
    endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench for the nonvolatile byte access controller
// assumes the cpu model file is compiled before this one
`timescale 1ns/10ps
module tb_top
    import eeac_pkg::*;
;
    localparam int DIV = 2;
    localparam int AT = 10;
    localparam int ST = 4;
    logic ref_clk, sys_rst, por_rst, gie;
    logic [7:0] bus_addr, bus_wdata, bus_rdata, q, d, d2;
    logic bus_io_space, bus_wr, bus_rd, bus_bit_set, bus_bit_clr, t;
    logic [2:0] bus_bit_idx;
    logic bus_bit_tst, cpu_stall, ready_irq, prog_busy;
    logic [8:0] a, b;
    logic [31:0] seed = 32'hAF463D16;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;

    // short programming counts keep the run brief
    eeac_top #(.OSC_DIV(DIV), .ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) eeac_top_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .por_rst(por_rst),
        .bus_addr(bus_addr), .bus_io_space(bus_io_space), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_bit_set(bus_bit_set), .bus_bit_clr(bus_bit_clr),
        .bus_bit_idx(bus_bit_idx), .bus_wdata(bus_wdata), .global_irq_en(gie),
        .bus_rdata(bus_rdata), .bus_bit_tst(bus_bit_tst), .cpu_stall(cpu_stall),
        .ready_irq(ready_irq), .prog_busy(prog_busy));
    eeac_cpu_model eeac_cpu_i (
        .ref_clk(ref_clk), .cpu_stall(cpu_stall), .bus_rdata(bus_rdata),
        .bus_bit_tst(bus_bit_tst), .bus_addr(bus_addr), .bus_io_space(bus_io_space),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_bit_set(bus_bit_set),
        .bus_bit_clr(bus_bit_clr), .bus_bit_idx(bus_bit_idx), .bus_wdata(bus_wdata));

    // clock and cycle count for programming durations
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // register helpers over the io bus
    task automatic rw(input logic [7:0] ad, input logic [7:0] v);
        eeac_cpu_i.acc(2'h0, ad, 1'b1, v, q, t);
    endtask
    task automatic rr(input logic [7:0] ad, input logic [7:0] e, input string nm);
        eeac_cpu_i.acc(2'h1, ad, 1'b1, 8'h00, q, t);
        chk(nm, {8'h00, q}, {8'h00, e});
    endtask
    task automatic bop(input logic [7:0] k);
        eeac_cpu_i.acc(2'h2, OFF_CONTROL, 1'b1, k, q, t);
    endtask
    task automatic setaddr(input logic [8:0] x);
        rw(OFF_ADDR_HIGH, {7'h00, x[8]});
        rw(OFF_ADDR_LOW, x[7:0]);
    endtask
    task automatic stall_cnt(output int n);
        n = 0;
        while (cpu_stall === 1'b1 && n < 10) begin
            n++;
            @(posedge ref_clk);
            #1;
        end
    endtask

    // opt 1 pokes registers while busy, opt 2 pulses sys_rst mid-cycle
    task automatic prog(input logic [1:0] m, input logic [8:0] x, input logic [7:0] v,
                        input int opt);
        int t0;
        int n;
        int tk;
        setaddr(x);
        rw(OFF_DATA, v);
        rw(OFF_CONTROL, {2'b00, m, 4'h8});
        bop(8'h02);
        bop(8'h01);
        t0 = cyc;
        stall_cnt(n);
        chk("prog_stall", 16'(n), 16'h0002);
        chk("busy", prog_busy, 1'b1);
        chk("irq_busy", ready_irq, 1'b0);
        if (opt == 1) begin
            rw(OFF_ADDR_LOW, ~x[7:0]);
            rw(OFF_CONTROL, 8'h18);
            bop(8'h00);
        end
        if (opt == 2) begin
            sys_rst = 1'b1;
            repeat (2) @(posedge ref_clk);
            #1;
            sys_rst = 1'b0;
            chk("busy_rst", prog_busy, 1'b1);
        end
        n = 0;
        while (prog_busy === 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        tk = (m == MODE_ATOMIC) ? AT : ST;
        n = ((cyc - t0) >= (tk - 1) * DIV) && ((cyc - t0) <= tk * DIV + DIV + 2);
        chk("prog_len", 16'(n), 16'h0001);
        chk("irq_ready", ready_irq, opt != 2);
    endtask

    task automatic rd_array(input logic [8:0] x, input logic [7:0] e);
        int n;
        eeac_cpu_i.wait_ready();
        setaddr(x);
        bop(8'h00);
        stall_cnt(n);
        chk("read_stall", 16'(n), 16'h0004);
        rr(OFF_DATA, e, "array_byte");
    endtask

    // a start refused: busy must stay low
    task automatic no_start(input string nm);
        bop(8'h01);
        @(posedge ref_clk);
        #1;
        chk(nm, prog_busy, 1'b0);
    endtask

    // main sequence
    initial begin
        sys_rst = 1'b1;
        por_rst = 1'b1;
        gie = 1'b0;
        repeat (12) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        por_rst = 1'b0;
        rr(OFF_CONTROL, 8'h00, "ctl_reset");
        rr(OFF_DATA, 8'h00, "data_reset");
        rr(8'h10, 8'h00, "unmapped");
        rw(OFF_ADDR_HIGH, 8'hFF);
        rr(OFF_ADDR_HIGH, 8'h01, "addr_high");
        seed = xs(seed);
        eeac_cpu_i.acc(2'h0, OFF_DATA, 1'b0, seed[7:0], q, t);
        rr(OFF_DATA, seed[7:0], "data_alias");
        bop(8'h03);
        eeac_cpu_i.acc(2'h1, OFF_CONTROL, 1'b1, 8'h03, q, t);
        chk("bit_test", t, 1'b1);
        chk("irq_gie_off", ready_irq, 1'b0);
        gie = 1'b1;
        #1;
        chk("irq_on", ready_irq, 1'b1);
        eeac_cpu_i.acc(2'h3, OFF_CONTROL, 1'b1, 8'h03, q, t);
        #1;
        chk("irq_cleared", ready_irq, 1'b0);
        bop(8'h03);
        // master window runs out, then reserved mode
        bop(8'h02);
        rr(OFF_CONTROL, 8'h0C, "master_set");
        repeat (4) @(posedge ref_clk);
        #1;
        rr(OFF_CONTROL, 8'h08, "master_clear");
        no_start("late_start");
        rw(OFF_CONTROL, 8'h38);
        bop(8'h02);
        no_start("mode_reserved");
        // erase, write-only twice, then atomic with probes while busy
        seed = xs(seed);
        a = seed[8:0];
        d = seed[15:8];
        d2 = seed[23:16];
        b = ~a;
        prog(MODE_ERASE, a, d, 0);
        rd_array(a, ERASED_BYTE);
        prog(MODE_WRITE, a, d, 0);
        rd_array(a, d);
        prog(MODE_WRITE, a, d2, 0);
        rd_array(a, d & d2);
        prog(MODE_ATOMIC, b, d2, 1);
        rr(OFF_ADDR_LOW, b[7:0], "addr_locked");
        rr(OFF_DATA, d2, "data_kept");
        rr(OFF_CONTROL, 8'h08, "mode_frozen");
        rd_array(b, d2);
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            prog(MODE_ATOMIC, seed[8:0], seed[23:16], 0);
            rd_array(seed[8:0], seed[23:16]);
        end
        prog(MODE_WRITE, a, 8'h00, 2);
        rr(OFF_CONTROL, 8'h20, "mode_kept");
        // the write cut by reset must still have landed
        rd_array(a, 8'h00);
        // reset while idle drops the mode back to atomic
        sys_rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        rr(OFF_CONTROL, 8'h00, "mode_reset");
        wrap_up();
    end

    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        wrap_up();
    end
endmodule
